// ---- logic/mcs_pkg.sv ----
// constants, register map and request carrier for the mailbox and semaphore block
// assumes one register port shared by all host interfaces, arbitrated upstream
package mcs_pkg;

   // widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int SRC_W = 3;
   localparam int OWN_W = 3;
   localparam int NUM_SEMA = 2;

   // register offsets (byte addresses, one word each)
   localparam logic [7:0] OFF_MAILBOX = 8'h00;
   localparam logic [7:0] OFF_MAILBOX_SET = 8'h04;
   localparam logic [7:0] OFF_MAILBOX_BIT_CLEAR_PORT = 8'h08;
   localparam logic [7:0] OFF_SEMAPHORE_IRQ_CONFIG = 8'h0c;
   localparam logic [7:0] OFF_SEMAPHORE_ZERO_CLAIM = 8'h10;
   localparam logic [7:0] OFF_SEMAPHORE_ONE_CLAIM = 8'h14;
   localparam logic [7:0] OFF_SEMAPHORE_ZERO_HOLDER = 8'h18;
   localparam logic [7:0] OFF_SEMAPHORE_ONE_HOLDER = 8'h1c;
   localparam logic [7:0] OFF_IRQ_MANUAL_TRIGGER = 8'h20;
   localparam logic [7:0] OFF_IRQ_ROUTE = 8'h24;

   // field positions
   localparam int CLAIM_BIT = 0;        // claim / release bit of a claim word
   localparam int POLARITY_LSB = 0;     // semaphore_irq_polarity, one bit per semaphore

   // reset values
   localparam logic [31:0] RST_MAILBOX = 32'h0000_0000;
   localparam logic [1:0] RST_POLARITY = 2'h0;
   localparam logic [1:0] RST_TRIGGER = 2'h0;
   localparam logic [1:0] RST_ROUTE = 2'h0;

   // identity of the interface that issued an access
   localparam logic [2:0] SRC_EMBEDDED = 3'h0;
   localparam logic [2:0] SRC_PCIE = 3'h1;
   localparam logic [2:0] SRC_PARALLEL_HOST_PORT = 3'h2;
   localparam logic [2:0] SRC_SERIAL_HOST_PORT = 3'h3;
   localparam logic [2:0] SRC_MANAGEMENT_SERIAL_SLAVE = 3'h4;

   // holder encoding read back from the holder registers
   localparam logic [2:0] OWN_FREE = 3'h0;
   localparam logic [2:0] OWN_EMBEDDED = 3'h1;
   localparam logic [2:0] OWN_PARALLEL = 3'h2;
   localparam logic [2:0] OWN_SERIAL = 3'h3;
   localparam logic [2:0] OWN_MANAGEMENT = 3'h4;

   // one register access as issued by the upstream arbiter
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
      logic [2:0] src;
   } mcs_req_type;

   // map an access source to the holder code it is recorded under
   function automatic logic [2:0] mcs_holder_of(input logic [2:0] src);
      logic [2:0] res;
      res = OWN_FREE;
      if (src == SRC_EMBEDDED || src == SRC_PCIE) res = OWN_EMBEDDED;
      else if (src == SRC_PARALLEL_HOST_PORT) res = OWN_PARALLEL;
      else if (src == SRC_SERIAL_HOST_PORT) res = OWN_SERIAL;
      else if (src == SRC_MANAGEMENT_SERIAL_SLAVE) res = OWN_MANAGEMENT;
      return res;
   endfunction : mcs_holder_of

endpackage : mcs_pkg

// ---- logic/mcs_mailbox_sema.sv ----
// mailbox word, two claim-by-read semaphores and their soft interrupts
// assumes all host interfaces are merged onto one register port upstream,
// one access per cycle, each tagged with the identity of its source
// limitation: a claim from a source outside the known set answers zero and
// takes nothing, so such a source can release a semaphore but never hold one
// all state clears on the asynchronous reset; no clock is needed while it is low
// the soft irqs are levels two flops behind the access that changes them
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/10ps

module mcs_mailbox_sema (
   input wire logic sys_clk_i,                   // 100 MHz register clock
   input wire logic arst_n_i,                    // asynchronous reset, active low
   input wire mcs_pkg::mcs_req_type req_i,       // one access with its source tag
   output logic [31:0] rdata_o,                  // read data, cycle after the read
   output logic [1:0] cpu_irq_o,                 // soft irqs routed to embedded cpu
   output logic [1:0] ext_irq_o                  // soft irqs routed to external pins
);

   // register state
   logic [31:0] mbox_q;
   logic [31:0] mbox_d;
   logic [1:0] polarity_q;
   logic [1:0] trigger_q;
   logic [1:0] route_q;
   logic [2:0] holder_q [2];
   logic [2:0] holder_d [2];
   logic [31:0] rdata_q;
   logic [1:0] cpu_irq_q;
   logic [1:0] ext_irq_q;

   // location decode
   wire hit_mbox = (req_i.addr == mcs_pkg::OFF_MAILBOX);
   wire hit_set = (req_i.addr == mcs_pkg::OFF_MAILBOX_SET);
   wire hit_clr = (req_i.addr == mcs_pkg::OFF_MAILBOX_BIT_CLEAR_PORT);
   wire hit_cfg = (req_i.addr == mcs_pkg::OFF_SEMAPHORE_IRQ_CONFIG);
   wire hit_trig = (req_i.addr == mcs_pkg::OFF_IRQ_MANUAL_TRIGGER);
   wire hit_route = (req_i.addr == mcs_pkg::OFF_IRQ_ROUTE);

   // write strobes per location
   wire wr_mbox = req_i.wr && hit_mbox;
   wire wr_set = req_i.wr && hit_set;
   wire wr_clr = req_i.wr && hit_clr;
   wire wr_cfg = req_i.wr && hit_cfg;
   wire wr_trig = req_i.wr && hit_trig;
   wire wr_route = req_i.wr && hit_route;

   // identity of the requester as a holder code; unknown sources never win
   wire [2:0] req_holder = mcs_pkg::mcs_holder_of(req_i.src);
   wire src_known = (req_holder != mcs_pkg::OWN_FREE);

   // mailbox next value: only one access per cycle reaches here, so every
   // update lands on the word left by the previous one
   // (a masked write can never race a direct write from another port)
   assign mbox_d = wr_mbox ? req_i.wdata :
                   wr_set ? (mbox_q | req_i.wdata) :
                   wr_clr ? (mbox_q & ~req_i.wdata) :
                   mbox_q;

   // mailbox storage
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mbox_q <= mcs_pkg::RST_MAILBOX;
      end else begin
         mbox_q <= mbox_d;
      end
   end

   // semaphore irq polarity: bit n set makes irq n assert while taken
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         polarity_q <= mcs_pkg::RST_POLARITY;
      end else if (wr_cfg) begin
         polarity_q <= req_i.wdata[mcs_pkg::POLARITY_LSB +: 2];
      end
   end

   // manual trigger: a level that holds irq n up until written back to zero
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         trigger_q <= mcs_pkg::RST_TRIGGER;
      end else if (wr_trig) begin
         trigger_q <= req_i.wdata[1:0];
      end
   end

   // routing: bit n set sends irq n to the external output
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         route_q <= mcs_pkg::RST_ROUTE;
      end else if (wr_route) begin
         route_q <= req_i.wdata[1:0];
      end
   end

   // every check below samples on the register clock and rests during reset
   default clocking mcs_cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!arst_n_i);

   // per-semaphore claim logic
   logic [1:0] hit_claim;
   logic [1:0] hit_holder;
   logic [1:0] claim_rd;
   logic [1:0] release_wr;
   logic [1:0] taken;
   logic [1:0] grant;
   logic [1:0] sema_level;
   logic [1:0] soft_irq;

   for (genvar i = 0; i < mcs_pkg::NUM_SEMA; i++) begin : g_sema
      localparam logic [7:0] CLAIM_OFF = (i == 0) ? mcs_pkg::OFF_SEMAPHORE_ZERO_CLAIM :
                                                    mcs_pkg::OFF_SEMAPHORE_ONE_CLAIM;
      localparam logic [7:0] HOLDER_OFF = (i == 0) ? mcs_pkg::OFF_SEMAPHORE_ZERO_HOLDER :
                                                     mcs_pkg::OFF_SEMAPHORE_ONE_HOLDER;

      // decode and claim/release qualification
      assign hit_claim[i] = (req_i.addr == CLAIM_OFF);
      assign hit_holder[i] = (req_i.addr == HOLDER_OFF);
      assign claim_rd[i] = req_i.rd && hit_claim[i];
      assign release_wr[i] = req_i.wr && hit_claim[i] && req_i.wdata[mcs_pkg::CLAIM_BIT];
      assign taken[i] = (holder_q[i] != mcs_pkg::OWN_FREE);
      // single port means two claims can never meet in one cycle;
      // back-to-back claims are taken in order, so the later one finds it taken
      assign grant[i] = claim_rd[i] && !taken[i] && src_known;

      // holder next value; a release from anyone frees it
      // a claim of a free semaphore records the requester's holder code
      assign holder_d[i] = release_wr[i] ? mcs_pkg::OWN_FREE :
                           grant[i] ? req_holder :
                           holder_q[i];

      // holder storage, independent per semaphore
      always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            holder_q[i] <= mcs_pkg::OWN_FREE;
         end else begin
            holder_q[i] <= holder_d[i];
         end
      end

      // semaphore i drives soft irq i; polarity 0 asserts on free, 1 on taken
      assign sema_level[i] = polarity_q[i] ? taken[i] : !taken[i];
      assign soft_irq[i] = sema_level[i] || trigger_q[i];

      // claim read from a known source that found it free answers one and records the holder
      chk_claim_grant: assert property (
         claim_rd[i] && !taken[i] && src_known
         |=> rdata_o == 32'h0000_0001 && holder_q[i] == $past(req_holder))
         else $error("free semaphore claim not granted");

      // claim read of a held semaphore answers zero and keeps the holder
      chk_claim_busy: assert property (
         claim_rd[i] && taken[i] |=> rdata_o == 32'h0000_0000 && $stable(holder_q[i]))
         else $error("held semaphore claim changed state or answered one");

      // once taken it stays taken through any number of claim reads
      chk_held_stays: assert property (
         taken[i] && !release_wr[i] |=> taken[i])
         else $error("semaphore freed without a release write");

      // writing one frees it no matter who writes
      chk_release_free: assert property (
         release_wr[i] |=> holder_q[i] == mcs_pkg::OWN_FREE)
         else $error("release write did not free semaphore");

      // write of zero to the claim bit does nothing
      chk_zero_write: assert property (
         req_i.wr && hit_claim[i] && !req_i.wdata[mcs_pkg::CLAIM_BIT] |=> $stable(holder_q[i]))
         else $error("claim write of zero altered holder");

      // holder register ignores writes
      chk_holder_ro: assert property (
         req_i.wr && hit_holder[i] |=> $stable(holder_q[i]))
         else $error("holder register was writable");

      // irq follows state and polarity two edges after the access
      chk_irq_level: assert property (
         $past(arst_n_i) |-> (cpu_irq_o[i] || ext_irq_o[i]) ==
                      ($past(sema_level[i]) || $past(trigger_q[i])))
         else $error("soft irq does not match semaphore state");

      // routing sends each irq to exactly one destination
      chk_irq_route: assert property (
         $past(arst_n_i) |-> !(cpu_irq_o[i] && ext_irq_o[i]) &&
                      (ext_irq_o[i] == ($past(soft_irq[i]) && $past(route_q[i]))))
         else $error("soft irq routed to wrong destination");

      // polarity 0 raises the irq while free, 1 while taken
      chk_irq_polarity: assert property (
         $past(arst_n_i) && !$past(trigger_q[i]) |->
            (cpu_irq_o[i] || ext_irq_o[i]) == ($past(polarity_q[i]) == $past(taken[i])))
         else $error("soft irq polarity or source mapping wrong");

      // route bit clear keeps the irq on the embedded cpu output
      chk_irq_cpu: assert property (
         $past(arst_n_i) |-> cpu_irq_o[i] == ($past(soft_irq[i]) && !$past(route_q[i])))
         else $error("soft irq missing on embedded cpu output");

      // a claim from a source outside the known set answers zero, takes nothing
      chk_unknown_src: assert property (
         claim_rd[i] && !src_known |=> rdata_o == 32'h0000_0000 && $stable(holder_q[i]))
         else $error("unknown source claim was granted");

      // holder register reads back the code held at the read
      chk_holder_read: assert property (
         req_i.rd && hit_holder[i] |=> rdata_o == {29'h0, $past(holder_q[i])})
         else $error("holder read returned wrong code");

      // claim answer carries nothing above the claim bit
      chk_claim_width: assert property (
         claim_rd[i] |=> rdata_o[31:1] == 31'h0)
         else $error("claim read answered stray upper bits");

      // a release from an interface other than the holder frees it as well
      chk_release_any: assert property (
         release_wr[i] && taken[i] && req_holder != holder_q[i] |=> !taken[i])
         else $error("release from another interface ignored");

      // a forced irq shows on one of the two outputs
      chk_force_irq: assert property (
         trigger_q[i] |=> cpu_irq_o[i] || ext_irq_o[i])
         else $error("manual trigger did not raise soft irq");

      // only the five holder codes ever appear
      chk_holder_code: assert property (
         holder_q[i] <= mcs_pkg::OWN_MANAGEMENT)
         else $error("holder register holds an undefined code");
   end

   // embedded cpu side: route bit clear keeps irq n here
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cpu_irq_q <= 2'h0;
      end else begin
         cpu_irq_q <= soft_irq & ~route_q;
      end
   end

   // external side: route bit set sends irq n out to another processor
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ext_irq_q <= 2'h0;
      end else begin
         ext_irq_q <= soft_irq & route_q;
      end
   end

   // read selection; claim words report the grant of this very access
   // (the holder only changes at the edge that takes the read, too late to answer from)
   wire [31:0] rd_word =
      hit_mbox ? mbox_q :
      hit_cfg ? {30'h0, polarity_q} :
      hit_claim[0] ? {31'h0, grant[0]} :
      hit_claim[1] ? {31'h0, grant[1]} :
      hit_holder[0] ? {29'h0, holder_q[0]} :
      hit_holder[1] ? {29'h0, holder_q[1]} :
      hit_trig ? {30'h0, trigger_q} :
      hit_route ? {30'h0, route_q} :
      32'h0000_0000;                                                 // set/clear and unmapped

   // read data valid only in the cycle after the read strobe
   // a zero between reads keeps stale claim answers off the bus
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= req_i.rd ? rd_word : 32'h0000_0000;
      end
   end

   assign rdata_o = rdata_q;
   assign cpu_irq_o = cpu_irq_q;
   assign ext_irq_o = ext_irq_q;

   // checks on the shared mailbox, then block-level checks on claims, read data and irq registers

   // direct write overwrites the whole word
   chk_mbox_write: assert property (
      wr_mbox |=> mbox_q == $past(req_i.wdata))
      else $error("mailbox direct write not applied");

   // clear mask drops only masked bits
   chk_mbox_clear: assert property (
      wr_clr |=> mbox_q == ($past(mbox_q) & ~$past(req_i.wdata)))
      else $error("mailbox clear mask misapplied");

   // set mask raises only masked bits
   chk_mbox_set: assert property (
      wr_set |=> mbox_q == ($past(mbox_q) | $past(req_i.wdata)))
      else $error("mailbox set mask misapplied");

   // no mailbox write, no change
   chk_mbox_hold: assert property (
      !(wr_mbox || wr_set || wr_clr) |=> $stable(mbox_q))
      else $error("mailbox changed without a write");

   // mailbox read returns the word held at the read
   chk_mbox_read: assert property (
      req_i.rd && hit_mbox |=> rdata_o == $past(mbox_q))
      else $error("mailbox read returned wrong word");

   // pcie and embedded processor recorded under one identity
   chk_pcie_alias: assert property (
      grant[1] && req_i.src == mcs_pkg::SRC_PCIE |=> holder_q[1] == mcs_pkg::OWN_EMBEDDED)
      else $error("pcie claim not recorded as embedded holder");

   // semaphore one holds its holder through any access other than its own claim word
   chk_sema_indep: assert property (
      !hit_claim[1] |=> $stable(holder_q[1]))
      else $error("semaphore one changed by foreign access");

   // back-to-back claims: the second one answers zero
   chk_single_win: assert property (
      grant[0] ##1 (claim_rd[0] && !release_wr[0]) |=> rdata_o == 32'h0000_0000)
      else $error("two claims both won semaphore zero");

   // read data stand only in the cycle after a read
   chk_rdata_idle: assert property (
      !req_i.rd |=> rdata_o == 32'h0000_0000)
      else $error("read data present without a read");

   // set and clear locations read back as zero
   chk_mask_read: assert property (
      req_i.rd && (hit_set || hit_clr) |=> rdata_o == 32'h0000_0000)
      else $error("mask location returned data");

   // polarity write lands in the config register
   chk_cfg_write: assert property (
      wr_cfg |=> polarity_q == $past(req_i.wdata[mcs_pkg::POLARITY_LSB +: 2]))
      else $error("polarity write not applied");

   // trigger write lands in the force register
   chk_trig_write: assert property (
      wr_trig |=> trigger_q == $past(req_i.wdata[1:0]))
      else $error("manual trigger write not applied");

   // route write lands in the routing register
   chk_route_write: assert property (
      wr_route |=> route_q == $past(req_i.wdata[1:0]))
      else $error("irq route write not applied");

   // main scenarios
   cov_claim_then_busy: cover property (grant[0] ##1 claim_rd[0] && taken[0]);
   cov_foreign_release: cover property (
      grant[1] ##[1:4] (release_wr[1] && req_i.src != $past(req_i.src)));
   cov_set_then_clear: cover property (wr_set ##[1:3] wr_clr);
   cov_forced_irq: cover property (trigger_q[1] && !sema_level[1] && ext_irq_o[1]);
   cov_unknown_claim: cover property (claim_rd[1] && !src_known);

endmodule : mcs_mailbox_sema

// ---- tb/mcs_host_model.sv ----
// host-side model: the cpus that reach the block through the merged register port
// assumes the block answers a read one cycle after the strobe edge and never stalls
`timescale 1ns/10ps

module mcs_host_model (
   input wire logic sys_clk_i,          // register clock
   input wire logic [31:0] rdata_i,     // read data from the block
   output mcs_pkg::mcs_req_type req_o   // access toward the block
);
   // idle port at time zero
   initial begin
      req_o = '0;
   end

   // one write: strobe high for one edge, then address and data turned over
   task automatic wr(input logic [2:0] src, input logic [7:0] addr, input logic [31:0] data);
      @(posedge sys_clk_i);
      req_o <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0, src: src};
      @(posedge sys_clk_i);
      req_o <= '{addr: ~addr, wdata: ~data, wr: 1'b0, rd: 1'b0, src: ~src};
   endtask : wr

   // one read: data taken in the cycle after the strobe edge
   task automatic rd(input logic [2:0] src, input logic [7:0] addr, output logic [31:0] data);
      @(posedge sys_clk_i);
      req_o <= '{addr: addr, wdata: 32'h0, wr: 1'b0, rd: 1'b1, src: src};
      @(posedge sys_clk_i);
      req_o <= '{addr: ~addr, wdata: 32'hffff_ffff, wr: 1'b0, rd: 1'b0, src: ~src};
      #1;
      data = rdata_i;
   endtask : rd

   // two reads back to back from two sources; each answer taken in its own cycle
   task automatic rd_pair(input logic [2:0] src_a, input logic [2:0] src_b,
                          input logic [7:0] addr, output logic [31:0] data_a,
                          output logic [31:0] data_b);
      @(posedge sys_clk_i);
      req_o <= '{addr: addr, wdata: 32'h0, wr: 1'b0, rd: 1'b1, src: src_a};
      @(posedge sys_clk_i);
      req_o <= '{addr: addr, wdata: 32'h0, wr: 1'b0, rd: 1'b1, src: src_b};
      #1;
      data_a = rdata_i;
      @(posedge sys_clk_i);
      req_o <= '{addr: ~addr, wdata: 32'hffff_ffff, wr: 1'b0, rd: 1'b0, src: ~src_b};
      #1;
      data_b = rdata_i;
   endtask : rd_pair

   // a semaphore is freed only by writing one to its claim bit
   task automatic release_sema(input logic [2:0] src, input logic [7:0] addr);
      wr(src, addr, 32'h0000_0001);
   endtask : release_sema
endmodule : mcs_host_model

// ---- tb/cpu_mailbox_semaphores_test.sv ----
// self-checking bench for the mailbox and semaphore block
// assumes the host model in tb/ speaks the single merged register port
`timescale 1ns/10ps

module cpu_mailbox_semaphores_test;
   logic sys_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   mcs_pkg::mcs_req_type req;
   logic [31:0] rdata;
   logic [1:0] cpu_irq;
   logic [1:0] ext_irq;
   int n_fail = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [31:0] v;
   logic [31:0] w;
   logic [1:0] pol_q, trig_q, route_q, held_q;
   logic [2:0] own_tab [5];

   always #5 sys_clk_i = ~sys_clk_i;

   mcs_host_model host (.sys_clk_i(sys_clk_i), .rdata_i(rdata), .req_o(req));
   mcs_mailbox_sema uut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .req_i(req),
      .rdata_o(rdata), .cpu_irq_o(cpu_irq), .ext_irq_o(ext_irq));

   // word compare
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // interrupt compare: expected level from the bench's own copy of state
   task automatic chk_irq();
      logic [1:0] lvl;
      lvl = (pol_q ~^ held_q) | trig_q;
      repeat (2) @(posedge sys_clk_i);
      #1;
      chk("cpu_irq", {30'h0, lvl & ~route_q}, {30'h0, cpu_irq});
      chk("ext_irq", {30'h0, lvl & route_q}, {30'h0, ext_irq});
   endtask : chk_irq

   // verdict and end of run
   task automatic results();
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : results

   // hang guard
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         $display("[FAIL] run length expected under 5000 seen 5000");
         results();
      end
   end

   // main sequence
   initial begin
      pol_q = 2'h0;
      trig_q = 2'h0;
      route_q = 2'h0;
      held_q = 2'h0;
      own_tab = '{mcs_pkg::OWN_EMBEDDED, mcs_pkg::OWN_EMBEDDED, mcs_pkg::OWN_PARALLEL,
         mcs_pkg::OWN_SERIAL, mcs_pkg::OWN_MANAGEMENT};
      repeat (3) @(posedge sys_clk_i);
      #1;
      chk("rdata in reset", 32'h0, rdata);
      chk("irq in reset", 32'h0, {28'h0, cpu_irq, ext_irq});
      @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      chk_irq();
      // mailbox: overwrite, then set and clear masks in turn
      host.rd(3'h0, mcs_pkg::OFF_MAILBOX, v);
      chk("mailbox reset", mcs_pkg::RST_MAILBOX, v);
      host.wr(3'h2, mcs_pkg::OFF_MAILBOX, 32'ha5a5_0f0f);
      host.rd(3'h3, mcs_pkg::OFF_MAILBOX, v);
      chk("mailbox write", 32'ha5a5_0f0f, v);
      host.wr(3'h4, mcs_pkg::OFF_MAILBOX_SET, 32'h0000_f0f1);
      host.wr(3'h1, mcs_pkg::OFF_MAILBOX_BIT_CLEAR_PORT, 32'ha000_0003);
      host.rd(3'h0, mcs_pkg::OFF_MAILBOX, v);
      chk("mailbox masks", 32'h05a5_fffc, v);
      host.rd(3'h0, mcs_pkg::OFF_MAILBOX_SET, v);
      chk("set location read", 32'h0, v);
      // semaphore zero claimed, refused while held, holder read-only
      host.rd(3'h2, mcs_pkg::OFF_SEMAPHORE_ZERO_CLAIM, v);
      chk("claim0 free", 32'h1, v);
      held_q[0] = 1'b1;
      host.rd(3'h2, mcs_pkg::OFF_SEMAPHORE_ZERO_CLAIM, v);
      chk("claim0 by holder", 32'h0, v);
      host.rd(3'h3, mcs_pkg::OFF_SEMAPHORE_ZERO_CLAIM, v);
      chk("claim0 held", 32'h0, v);
      host.wr(3'h4, mcs_pkg::OFF_SEMAPHORE_ZERO_CLAIM, 32'h0000_0000);
      host.wr(3'h4, mcs_pkg::OFF_SEMAPHORE_ZERO_HOLDER, 32'h0);
      host.rd(3'h4, mcs_pkg::OFF_SEMAPHORE_ZERO_HOLDER, v);
      chk("holder0", {29'h0, mcs_pkg::OWN_PARALLEL}, v);
      host.rd(3'h4, mcs_pkg::OFF_SEMAPHORE_ONE_CLAIM, v);
      chk("claim1 free", 32'h1, v);
      held_q[1] = 1'b1;
      chk_irq();
      host.release_sema(3'h3, mcs_pkg::OFF_SEMAPHORE_ZERO_CLAIM);
      held_q[0] = 1'b0;
      host.rd(3'h0, mcs_pkg::OFF_SEMAPHORE_ZERO_HOLDER, v);
      chk("holder0 released", {29'h0, mcs_pkg::OWN_FREE}, v);
      host.rd(3'h0, mcs_pkg::OFF_SEMAPHORE_ONE_HOLDER, v);
      chk("holder1", {29'h0, mcs_pkg::OWN_MANAGEMENT}, v);
      chk_irq();
      host.release_sema(3'h0, mcs_pkg::OFF_SEMAPHORE_ONE_CLAIM);
      held_q[1] = 1'b0;
      // every source claims semaphore one in turn
      for (int s = 0; s < 5; s++) begin
         host.rd(3'(s), mcs_pkg::OFF_SEMAPHORE_ONE_CLAIM, v);
         chk("claim1 per source", 32'h1, v);
         host.rd(3'h2, mcs_pkg::OFF_SEMAPHORE_ONE_HOLDER, v);
         chk("holder1 per source", {29'h0, own_tab[s]}, v);
         host.release_sema(3'h2, mcs_pkg::OFF_SEMAPHORE_ONE_CLAIM);
      end
      // two claims back to back: only the first one wins
      host.rd_pair(3'h0, 3'h3, mcs_pkg::OFF_SEMAPHORE_ZERO_CLAIM, v, w);
      chk("claim0 first of pair", 32'h1, v);
      chk("claim0 second of pair", 32'h0, w);
      host.rd(3'h2, mcs_pkg::OFF_SEMAPHORE_ZERO_HOLDER, v);
      chk("holder0 after pair", {29'h0, mcs_pkg::OWN_EMBEDDED}, v);
      host.release_sema(3'h4, mcs_pkg::OFF_SEMAPHORE_ZERO_CLAIM);
      // a source outside the known set never takes a semaphore
      host.rd(3'h5, mcs_pkg::OFF_SEMAPHORE_ONE_CLAIM, v);
      chk("claim1 unknown source", 32'h0, v);
      host.rd(3'h2, mcs_pkg::OFF_SEMAPHORE_ONE_HOLDER, v);
      chk("holder1 unknown source", {29'h0, mcs_pkg::OWN_FREE}, v);
      // polarity, manual trigger and routing
      host.wr(3'h0, mcs_pkg::OFF_SEMAPHORE_IRQ_CONFIG, 32'h0000_0001);
      pol_q = 2'h1;
      host.rd(3'h3, mcs_pkg::OFF_SEMAPHORE_ZERO_CLAIM, v);
      chk("claim0 serial", 32'h1, v);
      held_q[0] = 1'b1;
      chk_irq();
      host.wr(3'h0, mcs_pkg::OFF_IRQ_MANUAL_TRIGGER, 32'h0000_0002);
      trig_q = 2'h2;
      host.wr(3'h0, mcs_pkg::OFF_SEMAPHORE_IRQ_CONFIG, 32'h0000_0003);
      pol_q = 2'h3;
      chk_irq();
      host.wr(3'h0, mcs_pkg::OFF_IRQ_ROUTE, 32'h0000_0001);
      route_q = 2'h1;
      chk_irq();
      host.wr(3'h0, mcs_pkg::OFF_IRQ_ROUTE, 32'h0000_0002);
      route_q = 2'h2;
      host.wr(3'h0, mcs_pkg::OFF_IRQ_MANUAL_TRIGGER, 32'h0000_0000);
      trig_q = 2'h0;
      chk_irq();
      results();
   end
endmodule : cpu_mailbox_semaphores_test
